// ==== logic/sdc_regs.svh ====
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: included by the bus direction controller and its test bench
// Notes: byte addresses on a 32-bit AXI4-Lite register bus
//
// Overview of operation
// - five-state controller sets line enables and data drive.
// - only enables drivers; bus levels always come from far side.
// - 400 ns timer counts ref clock edges at exactly 20 or 40 MHz.
// - state changes on the aclk edge after all transition conditions hold.
// - after reset wait in bus free until B busy and select quiet 400 ns.
// - in bus free, B busy and select levels pass to the A side.
// - arbitration enables both busy drivers until the state is left.
// - B select asserted during arbitration moves to first selection.
// - arbitration timeout without B select resets the controller.
// - in first selection the winner latch follows B select.
// - in first selection the reconnect latch follows A in/out.
// - A-side winner passes busy and select to B, waits A busy quiet 400 ns.
// - test mode: filtered reset picks phase direction; timeout floats.
`ifndef SDC_REGS_SVH
`define SDC_REGS_SVH

`define SDC_CTRL_OFS 8'h00
`define SDC_STAT_OFS 8'h04
`define SDC_CTRL_CLK40_BIT 0
`define SDC_CTRL_TEST_BIT 1
`define SDC_CTRL_RST 2'h0
`define SDC_STAT_WIN_BIT 4
`define SDC_STAT_RCN_BIT 5
`define SDC_QUIET_NS 400
`define SDC_REF20_MHZ 20
`define SDC_REF40_MHZ 40
`define SDC_TICKS20 ((`SDC_QUIET_NS * `SDC_REF20_MHZ) / 1000)
`define SDC_TICKS40 ((`SDC_QUIET_NS * `SDC_REF40_MHZ) / 1000)
`define SDC_RESP_OK 2'h0
`define SDC_RESP_DEC 2'h3

`endif

// ==== logic/sdc_pkg.sv ====
// Purpose: types shared by the bus direction controller
// Assumes: sdc_regs.svh holds every number
// Notes: pin groups travel as packed structs
package sdc_pkg;

    // controller states
    typedef enum logic [2:0] {
        ST_BUS_FREE,
        ST_ARBIT,
        ST_SELECT1,
        ST_SELECT2,
        ST_XFER
    } sdc_state_t;

    // pin levels into the block, true means asserted; filtered reset is active low
    typedef struct packed {
        logic ref_clk_in;
        logic timeout_in;
        logic diff_sense_in;
        logic test_sel_in;
        logic filtered_reset_in;
        logic a_side_in_out;
        logic a_side_select;
        logic a_side_busy;
        logic b_side_select;
        logic b_side_busy;
    } sdc_pins_t;

    // driver enables and data-transceiver controls
    typedef struct packed {
        logic busy_a_oe;
        logic busy_b_oe;
        logic sel_a_oe;
        logic sel_b_oe;
        logic phase_a2b_oe;
        logic phase_b2a_oe;
        logic xcvr_drive_enable;
        logic data_direction_out;
        logic timeout_out;
        logic timeout_oe;
    } sdc_drv_t;

endpackage : sdc_pkg

// ==== logic/sdc_ctrl.sv ====
// Purpose: bus-watching direction controller with AXI4-Lite status
// Assumes: pins are asynchronous and pass a three-stage filter
// Notes: transitions take effect one aclk edge after the filtered
//        conditions hold; outputs all come from flip-flops
//
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`include "sdc_regs.svh"

module sdc_ctrl (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire sdc_pkg::sdc_pins_t pins_in,
    output sdc_pkg::sdc_drv_t drv_out
);
    import sdc_pkg::*;

    localparam int NP = $bits(sdc_pins_t);

    // ----------------------------------------
    // pin filter
    // ----------------------------------------
    logic [NP-1:0] s1_r;
    logic [NP-1:0] s2_r;
    logic [NP-1:0] s3_r;
    logic [NP-1:0] lvl_r;
    sdc_pins_t pf;

    genvar gi;
    generate
        for (gi = 0; gi < NP; gi++) begin : g_sync
            // a level counts only once two late stages agree
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    s1_r[gi] <= 1'b0;
                    s2_r[gi] <= 1'b0;
                    s3_r[gi] <= 1'b0;
                    lvl_r[gi] <= 1'b0;
                end else begin
                    s1_r[gi] <= pins_in[gi];
                    s2_r[gi] <= s1_r[gi];
                    s3_r[gi] <= s2_r[gi];
                    if (s2_r[gi] == s3_r[gi]) begin
                        lvl_r[gi] <= s3_r[gi];
                    end
                end
            end
        end
    endgenerate

    assign pf = sdc_pins_t'(lvl_r);

    // ----------------------------------------
    // software control
    // ----------------------------------------
    logic [1:0] ctrl_r;
    logic clk40_sel;
    logic test_mode;

    assign clk40_sel = ctrl_r[`SDC_CTRL_CLK40_BIT];
    // test override needs both the pin and the software bit,
    // so a stray pin level cannot hijack a live bus
    assign test_mode = ctrl_r[`SDC_CTRL_TEST_BIT] & pf.test_sel_in;

    // ----------------------------------------
    // controller state
    // ----------------------------------------
    sdc_state_t state_r;
    sdc_state_t state_nxt;
    logic win_r;
    logic rcn_r;
    logic tmo_d_r;
    logic quiet_done;
    logic ctl_clear;
    logic tmo_event;

    // filtered reset low clears the controller like a bus reset
    assign ctl_clear = ~pf.filtered_reset_in | test_mode;
    // timeout pin rises back once the rc charge has run out
    assign tmo_event = pf.timeout_in & ~tmo_d_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tmo_d_r <= 1'b0;
        end else begin
            tmo_d_r <= pf.timeout_in;
        end
    end

    // watched lines for the quiet timer, per state
    function automatic logic busy_lines(
        input sdc_state_t st,
        input sdc_pins_t p,
        input logic win
    );
        logic r;
        r = p.b_side_busy | p.b_side_select;
        if (st == ST_SELECT1 && !win) begin
            r = p.a_side_busy;
        end
        return r;
    endfunction

    // next state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_BUS_FREE: begin
                if (quiet_done) begin
                    state_nxt = ST_ARBIT;
                end
            end
            ST_ARBIT: begin
                if (pf.b_side_select) begin
                    state_nxt = ST_SELECT1;
                end else if (tmo_event) begin
                    state_nxt = ST_BUS_FREE;
                end
            end
            ST_SELECT1: begin
                if (!win_r && quiet_done) begin
                    state_nxt = ST_SELECT2;
                end else if (win_r && pf.a_side_busy
                             && !pf.b_side_busy) begin
                    state_nxt = ST_SELECT2;
                end else if (win_r && quiet_done) begin
                    state_nxt = ST_ARBIT;
                end
            end
            ST_SELECT2: begin
                if (!pf.b_side_select && !pf.a_side_select) begin
                    state_nxt = ST_XFER;
                end
            end
            ST_XFER: begin
                if (quiet_done) begin
                    state_nxt = ST_ARBIT;
                end
            end
            default: state_nxt = ST_BUS_FREE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= ST_BUS_FREE;
        end else if (ctl_clear) begin
            state_r <= ST_BUS_FREE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            win_r <= 1'b0;
        end else if (state_r == ST_ARBIT
                     || state_r == ST_SELECT1) begin
            win_r <= pf.b_side_select;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rcn_r <= 1'b0;
        end else if (state_r == ST_ARBIT
                     || state_r == ST_SELECT1) begin
            rcn_r <= pf.a_side_in_out;
        end
    end

    // ----------------------------------------
    // 400 ns quiet timer
    // ----------------------------------------
    logic [4:0] qcnt_r;
    logic ref_d_r;
    logic ref_tick;
    logic [4:0] qlimit;

    assign ref_tick = pf.ref_clk_in & ~ref_d_r;
    assign qlimit = clk40_sel ? 5'(`SDC_TICKS40) : 5'(`SDC_TICKS20);
    assign quiet_done = (qcnt_r >= qlimit);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ref_d_r <= 1'b0;
        end else begin
            ref_d_r <= pf.ref_clk_in;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            qcnt_r <= 5'h00;
        end else if (ctl_clear || state_nxt != state_r
                     || busy_lines(state_r, pf, win_r)) begin
            qcnt_r <= 5'h00;
        end else if (ref_tick && !quiet_done) begin
            qcnt_r <= qcnt_r + 5'h01;
        end
    end

    // ----------------------------------------
    // driver enables
    // ----------------------------------------
    sdc_drv_t drv_nxt;
    sdc_drv_t drv_r;

    always_comb begin
        drv_nxt = '0;
        drv_nxt.timeout_out = 1'b1;
        drv_nxt.timeout_oe = 1'b1;
        drv_nxt.data_direction_out = pf.a_side_in_out;
        unique case (state_r)
            ST_BUS_FREE: begin
                drv_nxt.busy_a_oe = 1'b1;
                drv_nxt.sel_a_oe = 1'b1;
            end
            ST_ARBIT: begin
                drv_nxt.busy_a_oe = 1'b1;
                drv_nxt.busy_b_oe = 1'b1;
                drv_nxt.sel_a_oe = 1'b1;
                drv_nxt.timeout_oe = 1'b0;
            end
            ST_SELECT1, ST_SELECT2, ST_XFER: begin
                drv_nxt.busy_b_oe = ~win_r;
                drv_nxt.sel_b_oe = ~win_r;
                drv_nxt.busy_a_oe = win_r;
                drv_nxt.sel_a_oe = win_r;
                // initiator side drives phase lines on selection
                drv_nxt.phase_a2b_oe = ~(win_r ^ rcn_r);
                drv_nxt.phase_b2a_oe = win_r ^ rcn_r;
                drv_nxt.xcvr_drive_enable =
                    (state_r == ST_XFER) | ~win_r;
            end
            default: drv_nxt = '0;
        endcase
        if (test_mode) begin
            drv_nxt = '0;
            drv_nxt.phase_a2b_oe = pf.filtered_reset_in;
            drv_nxt.phase_b2a_oe = ~pf.filtered_reset_in;
            drv_nxt.xcvr_drive_enable = ~pf.b_side_select
                | (pf.b_side_busy & ~pf.timeout_in);
            drv_nxt.data_direction_out = pf.a_side_in_out;
            drv_nxt.timeout_out = 1'b1;
            drv_nxt.timeout_oe = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            drv_r <= '0;
        end else begin
            drv_r <= drv_nxt;
        end
    end

    assign drv_out = drv_r;

    // ----------------------------------------
    // axi4-lite write side
    // ----------------------------------------
    logic aw_hold_r;
    logic [7:0] aw_addr_r;
    logic w_hold_r;
    logic [31:0] w_data_r;
    logic w_strb0_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic wr_go;

    assign s_axi_awready = ~aw_hold_r & ~bvalid_r;
    assign s_axi_wready = ~w_hold_r & ~bvalid_r;
    assign wr_go = aw_hold_r & w_hold_r & ~bvalid_r;

    // address and data land in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_hold_r <= 1'b0;
            w_data_r <= 32'h0000_0000;
            w_strb0_r <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_hold_r <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb0_r <= s_axi_wstrb[0];
            end else if (wr_go) begin
                w_hold_r <= 1'b0;
            end
        end
    end

    // control register; status is read only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= `SDC_CTRL_RST;
        end else if (wr_go && aw_addr_r == `SDC_CTRL_OFS
                     && w_strb0_r) begin
            ctrl_r <= w_data_r[1:0];
        end
    end

    // write answer one edge after both halves are held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r <= `SDC_RESP_OK;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r <= (aw_addr_r == `SDC_CTRL_OFS
                        || aw_addr_r == `SDC_STAT_OFS)
                       ? `SDC_RESP_OK : `SDC_RESP_DEC;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    // ----------------------------------------
    // axi4-lite read side
    // ----------------------------------------
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;

    assign s_axi_arready = ~rvalid_r;

    // status shows state, both latches and filtered lines
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= `SDC_RESP_OK;
        end else if (s_axi_arvalid && !rvalid_r) begin
            rvalid_r <= 1'b1;
            rresp_r <= `SDC_RESP_OK;
            rdata_r <= 32'h0000_0000;
            if (s_axi_araddr == `SDC_CTRL_OFS) begin
                rdata_r[1:0] <= ctrl_r;
            end else if (s_axi_araddr == `SDC_STAT_OFS) begin
                rdata_r[2:0] <= state_r;
                rdata_r[`SDC_STAT_WIN_BIT] <= win_r;
                rdata_r[`SDC_STAT_RCN_BIT] <= rcn_r;
                rdata_r[8 +: NP] <= lvl_r;
            end else begin
                rresp_r <= `SDC_RESP_DEC;
            end
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

endmodule : sdc_ctrl

// ==== sim/sdc_ctrl_properties.sv ====
// Purpose: concurrent checks on the bus direction controller ports
// Assumes: bound to sdc_ctrl from the bench top file
// Notes: pin filter plus state and output registers give 6 edges latency
`timescale 1ns/1ps

module sdc_ctrl_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire sdc_pkg::sdc_pins_t pins_in,
    input wire sdc_pkg::sdc_drv_t drv_out
);
    import sdc_pkg::*;

    logic [7:0] quiet_r;

    // ----------------------------------------
    // quiet counter
    // ----------------------------------------
    // cycles since a b-side busy or select level was last high
    always_ff @(posedge aclk) begin
        if (pins_in.b_side_busy || pins_in.b_side_select) begin
            quiet_r <= 8'h00;
        end else if (quiet_r != 8'hff) begin
            quiet_r <= quiet_r + 8'h01;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_rst_drv_off: assert property (disable iff (1'b0)
        !aresetn |=> drv_out == '0) else $error("drivers on in reset");
    a_free_after_rst: assert property ($rose(aresetn) |-> ##2
        (drv_out.busy_a_oe && drv_out.sel_a_oe && !drv_out.busy_b_oe))
        else $error("bus free pass-through missing");
    // only arbitration turns both busy drivers on together
    a_arb_both_busy: assert property (
        $rose(drv_out.busy_a_oe && drv_out.busy_b_oe) |-> !drv_out.timeout_oe)
        else $error("arbitration enables wrong");
    // quiet window is 400 ns, i.e. 100 cycles less ref clock jitter
    a_quiet_first: assert property (
        $rose(drv_out.busy_a_oe && drv_out.busy_b_oe) |-> quiet_r >= 8'h50)
        else $error("arbitration before quiet window");
    a_phase_excl: assert property (
        !(drv_out.phase_a2b_oe && drv_out.phase_b2a_oe))
        else $error("both phase directions on");
    a_tmo_high: assert property (
        drv_out.timeout_oe |-> drv_out.timeout_out)
        else $error("timeout pin driven low");
    a_freset_hold: assert property (
        !pins_in.filtered_reset_in [*8] |-> !drv_out.busy_b_oe)
        else $error("filtered reset did not clear");
    a_sel_one_way: assert property (
        !(drv_out.sel_a_oe && drv_out.sel_b_oe))
        else $error("select driven both ways");
    a_rd_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");

    c_arb: cover property ($rose(drv_out.busy_b_oe));
    c_test: cover property (drv_out.phase_a2b_oe);
    c_read: cover property (s_axi_rvalid);
endmodule : sdc_ctrl_props

// ==== sim/sdc_bus_model.sv ====
// Purpose: far side model, reference oscillator and bus line levels
// Assumes: bench sets the wanted line levels in lv
// Notes: a-side activity is held back until arbitration is seen
`timescale 1ns/1ps

module sdc_bus_model (
    input wire logic clk40,
    input wire sdc_pkg::sdc_pins_t lv,
    input wire sdc_pkg::sdc_drv_t drv,
    output sdc_pkg::sdc_pins_t pins
);
    import sdc_pkg::*;

    logic ref_clk;
    logic seen_arb;

    initial begin
        ref_clk = 1'b0;
        forever #(clk40 ? 12.5 : 25.0) ref_clk = ~ref_clk;
    end

    initial seen_arb = 1'b0;
    always @(posedge drv.busy_b_oe) seen_arb = 1'b1;

    // pass the levels, gating the lone a-side device
    always_comb begin
        pins = lv;
        pins.ref_clk_in = ref_clk;
        pins.a_side_select = lv.a_side_select & seen_arb;
        pins.a_side_busy = lv.a_side_busy & seen_arb;
    end
endmodule : sdc_bus_model

// ==== sim/test_scsi_direction_controller.sv ====
// Purpose: self-checking bench for the bus direction controller
// Assumes: the bus model supplies the reference clock and line levels
// Notes: state is polled over the register bus with bounded retries
`timescale 1ns/1ps
`include "sdc_regs.svh"

bind sdc_ctrl sdc_ctrl_props u_props (.*);

module test_scsi_direction_controller;
    import sdc_pkg::*;

    logic aclk, aresetn, clk40, io;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    sdc_pins_t lv, pins_in;
    sdc_drv_t drv_out;
    int miscompares, n_checks;

    sdc_ctrl u_dut (.*);
    sdc_bus_model u_bus (.clk40(clk40), .lv(lv), .drv(drv_out),
        .pins(pins_in));

    // 250 MHz
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic close_out;
        if (miscompares == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v,
        output logic [1:0] rs);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        // only the watchdog ends a wait for the answer
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] q,
        output logic [1:0] rs);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        q = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_rd

    // poll the status state field, bounded by lim reads
    task automatic wait_st(input logic [2:0] e, input int lim);
        int i;
        i = 0;
        do begin
            axi_rd(`SDC_STAT_OFS, d, r);
            i++;
        end while (d[2:0] !== e && i < lim);
        chk("state", {29'h0, d[2:0]}, {29'h0, e});
    endtask : wait_st

    // a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge aclk);
        miscompares++;
        close_out();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'hbb6f9081));
        {aresetn, clk40, io} = 3'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        lv = '0;
        lv.filtered_reset_in = 1'b1;
        lv.b_side_busy = 1'b1;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(`SDC_CTRL_OFS, d, r);
        chk("ctrl_rst", d, 32'h0);
        chk("rresp", {30'h0, r}, 32'h0);
        chk("free_oe", {26'h0, drv_out.busy_a_oe, drv_out.busy_b_oe,
            drv_out.sel_a_oe, drv_out.sel_b_oe, drv_out.timeout_out,
            drv_out.timeout_oe}, 32'h2b);
        axi_wr(8'h08, 32'h5, r);
        chk("wr_unmap", {30'h0, r}, 32'h3);
        axi_rd(8'h0c, d, r);
        chk("rd_unmap", {30'h0, r}, 32'h3);
        // busy pulses with gaps shorter than the quiet window
        repeat (6) begin
            repeat ($urandom_range(10, 20)) @(posedge aclk);
            lv.b_side_busy <= 1'b0;
            lv.b_side_select <= 1'b0;
            repeat ($urandom_range(20, 70)) @(posedge aclk);
            lv.b_side_busy <= 1'($urandom_range(0, 1));
            lv.b_side_select <= 1'b1;
        end
        repeat (10) @(posedge aclk);
        wait_st(3'h0, 1);
        lv.b_side_busy <= 1'b0;
        lv.b_side_select <= 1'b0;
        repeat (60) @(posedge aclk);
        wait_st(3'h0, 1);
        wait_st(3'h1, 60);
        chk("arb_oe", {29'h0, drv_out.busy_a_oe, drv_out.busy_b_oe,
            drv_out.timeout_oe}, 32'h6);
        lv.timeout_in <= 1'b1;
        wait_st(3'h0, 20);
        lv.timeout_in <= 1'b0;
        wait_st(3'h1, 60);
        io = 1'($urandom_range(0, 1));
        lv.a_side_in_out <= io;
        lv.b_side_select <= 1'b1;
        wait_st(3'h2, 20);
        chk("win", {31'h0, d[`SDC_STAT_WIN_BIT]}, 32'h1);
        chk("rcn", 32'(d[`SDC_STAT_RCN_BIT]), 32'(io));
        lv.a_side_in_out <= !io;
        repeat (8) @(posedge aclk);
        axi_rd(`SDC_STAT_OFS, d, r);
        chk("rcn2", 32'(d[`SDC_STAT_RCN_BIT]), 32'(!io));
        // a-side winner: b select drops while a busy holds the bus
        {lv.a_side_busy, lv.b_side_busy, lv.b_side_select} <= 3'h6;
        repeat (12) @(posedge aclk);
        lv.b_side_busy <= 1'b0;
        axi_rd(`SDC_STAT_OFS, d, r);
        chk("a_win", {28'h0, d[`SDC_STAT_WIN_BIT], d[2:0]}, 32'h2);
        chk("a_win_oe", {28'h0, drv_out.busy_a_oe, drv_out.busy_b_oe,
            drv_out.sel_a_oe, drv_out.sel_b_oe}, 32'h5);
        // a busy must stay quiet the full window before moving on
        lv.a_side_busy <= 1'b0;
        repeat (60) @(posedge aclk);
        wait_st(3'h2, 1);
        wait_st(3'h4, 60);
        chk("xfer_drv", {30'h0, drv_out.xcvr_drive_enable,
            drv_out.data_direction_out}, {30'h0, 1'b1, !io});
        lv.filtered_reset_in <= 1'b0;
        lv.b_side_select <= 1'b0;
        wait_st(3'h0, 20);
        axi_wr(`SDC_CTRL_OFS, 32'h1, r);
        clk40 <= 1'b1;
        axi_rd(`SDC_CTRL_OFS, d, r);
        chk("ctrl_rd", d, 32'h1);
        lv.filtered_reset_in <= 1'b1;
        repeat (60) @(posedge aclk);
        wait_st(3'h0, 1);
        wait_st(3'h1, 60);
        axi_wr(`SDC_CTRL_OFS, 32'h3, r);
        lv.test_sel_in <= 1'b1;
        // filtered reset picks the phase direction in test mode
        for (int fr = 1; fr >= 0; fr--) begin
            lv.filtered_reset_in <= fr[0];
            repeat (8) @(posedge aclk);
            chk("test_oe", {29'h0, drv_out.phase_a2b_oe,
                drv_out.phase_b2a_oe, drv_out.timeout_oe},
                {29'h0, fr[0], !fr[0], 1'b0});
        end
        close_out();
    end
endmodule : test_scsi_direction_controller
